// ### hw/asr_consts.vh
// Purpose: Constants for the alarm and general status register bank
// Assumes: Register addresses are 8-bit register indexes of the serial port
// Notes: Included by the status bank module
`ifndef ASR_CONSTS_VH
`define ASR_CONSTS_VH
`define ASR_ADDR_ALARM 8'h1E
`define ASR_ADDR_GENERAL 8'h1F
`define ASR_RESET_WORD 16'h0000
`define ASR_ZERO_WORD 16'h0000
`define ASR_ZERO_NIBBLE 4'h0
`define ASR_ZERO_CHAN 4'h0
`define ASR_ZERO_BIT 1'h0
`define ASR_ONE_BIT 1'h1
// Alarm word positions
`define ASR_A_OUT4 15
`define ASR_A_OUT3 14
`define ASR_A_OUT2 13
`define ASR_A_OUT1 12
`define ASR_A_RSVD 11
`define ASR_A_NEG 10
`define ASR_A_R2_HI 9
`define ASR_A_R2_LO 8
`define ASR_A_R1_HI 7
`define ASR_A_R1_LO 6
`define ASR_A_LT_HI 5
`define ASR_A_LT_LO 4
`define ASR_A_CH_MSB 3
`define ASR_A_CH_LSB 0
// General word positions
`define ASR_G_ANY 15
`define ASR_G_READY 14
`define ASR_G_DAV_MSB 13
`define ASR_G_DAV_LSB 8
`define ASR_G_RSVD_MSB 7
`define ASR_G_RSVD_LSB 4
`define ASR_G_SLEEP2 3
`define ASR_G_SLEEP1 2
`define ASR_G_AMP 1
`define ASR_G_GLOBAL 0
`endif

// ### hw/asr_sync.v
// Purpose: Two-flop synchroniser for a bus of pin levels
// Assumes: Inputs are asynchronous to CLK
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module asr_sync #(
  parameter WIDTH = 3
) (
  input wire CLK,
  input wire RESET_N,
  input wire [WIDTH-1:0] D,
  output reg [WIDTH-1:0] Q
);
  reg [WIDTH-1:0] meta;
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      meta <= {WIDTH{1'b0}};
      Q <= {WIDTH{1'b0}};
    end else begin
      meta <= D;
      Q <= meta;
    end
  end
endmodule // asr_sync
`default_nettype wire

// ### hw/asr_status_bank.v
// Purpose: Alarm status and general status read-only registers
// Assumes: Conversion results arrive with one-cycle update strobes
// Notes: Registers read at index 0x1E and 0x1F; other reads return zero
// Function
// (RULE1) Outputs 4,3 over pair B limit set 15,14
// (RULE2) Outputs 2,1 over pair A limit set 13,12
// (RULE3) Alarm bit 11 reads zero
// (RULE4) Negative supply out of range sets bit 10
// (RULE5) Remote sensors high/low set bits 9..6
// (RULE6) Disabled remote sensor forces its alarms zero
// (RULE7) Local temperature high bit 5, low 4
// (RULE8) Disabled local sensor holds alarms zero
// (RULE9) Channel alarms bits 3..0, source per mode
// (RULE10) Alarm word read-only at 0x1E, resets zero
// (RULE11) General word read-only at 0x1F, resets zero
// (RULE12) General upper byte holds ready flags
// (RULE13) Lower byte: zeros, pin levels, global alarm
// (RULE14) ADC ready only when idle awaiting trigger
// (RULE15) Amp enable bit is one when on
// (RULE16) Select bit picks internal inputs or sense
// (RULE17) Alarms follow latest compare; reads are harmless
`timescale 1ns/1ps
`default_nettype none
`include "asr_consts.vh"
module asr_status_bank #(
  parameter DW = 12,
  parameter CH = 4
) (
  input wire CLK,
  input wire RESET_N,
  input wire [7:0] RD_ADDR,
  output reg [15:0] RD_DATA,
  input wire [DW-1:0] OUT1_CODE,
  input wire [DW-1:0] OUT2_CODE,
  input wire [DW-1:0] OUT3_CODE,
  input wire [DW-1:0] OUT4_CODE,
  input wire [DW-1:0] PAIR_A_UPPER_LIMIT,
  input wire [DW-1:0] PAIR_B_UPPER_LIMIT,
  input wire OUT_CODES_UPDATE,
  input wire NEG_SUPPLY_FAULT,
  input wire NEG_SUPPLY_UPDATE,
  input wire [DW-1:0] LOCAL_TEMP,
  input wire [DW-1:0] LOCAL_HIGH,
  input wire [DW-1:0] LOCAL_LOW,
  input wire LOCAL_ENABLE,
  input wire LOCAL_UPDATE,
  input wire [DW-1:0] REMOTE_ONE_TEMP,
  input wire [DW-1:0] REMOTE_ONE_HIGH,
  input wire [DW-1:0] REMOTE_ONE_LOW,
  input wire REMOTE_ONE_ENABLE,
  input wire REMOTE_ONE_UPDATE,
  input wire [DW-1:0] REMOTE_TWO_TEMP,
  input wire [DW-1:0] REMOTE_TWO_HIGH,
  input wire [DW-1:0] REMOTE_TWO_LOW,
  input wire REMOTE_TWO_ENABLE,
  input wire REMOTE_TWO_UPDATE,
  input wire [CH*DW-1:0] INTERNAL_VALUES,
  input wire [CH*DW-1:0] SENSE_VALUES,
  input wire [CH*DW-1:0] CHAN_HIGH,
  input wire [CH*DW-1:0] CHAN_LOW,
  input wire [CH-1:0] CHAN_UPDATE,
  input wire COMPARE_SOURCE_SELECT,
  input wire [5:0] READY_FLAGS,
  input wire ADC_IDLE,
  input wire CONFIG_BUSY,
  input wire [CH-1:0] ALARM_ENABLE,
  input wire [11:0] OTHER_ALARM_ENABLE,
  input wire SLEEP_PIN_ONE,
  input wire SLEEP_PIN_TWO,
  input wire AMP_ENABLE_PIN,
  output wire [15:0] ALARM_FLAGS,
  output wire [15:0] GENERAL_FLAGS
);
  ////////////////////////////////////////////////////////////////////////
  // Range compare used by the channel alarms
  function out_of_range;
    input [DW-1:0] value;
    input [DW-1:0] high;
    input [DW-1:0] low;
    begin
      out_of_range = (value > high) || (value < low);
    end
  endfunction

  reg out4_over_limit, out3_over_limit, out2_over_limit, out1_over_limit;
  reg neg_supply_fault;
  reg remote_two_over_temp, remote_two_under_temp;
  reg remote_one_over_temp, remote_one_under_temp;
  reg local_over_temp, local_under_temp;
  reg [CH-1:0] chan_range_fault;
  reg [5:0] ready_flags;
  reg adc_ready;
  wire [2:0] pins_sync;
  wire sleep_pin_one_level = pins_sync[0];
  wire sleep_pin_two_level = pins_sync[1];
  wire amp_enable_pin_level = pins_sync[2];

  asr_sync #(.WIDTH(3)) u_pin_sync (
    .CLK(CLK),
    .RESET_N(RESET_N),
    .D({AMP_ENABLE_PIN, SLEEP_PIN_TWO, SLEEP_PIN_ONE}),
    .Q(pins_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // Output limit and supply alarms
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      out4_over_limit <= `ASR_ZERO_BIT;
      out3_over_limit <= `ASR_ZERO_BIT;
      out2_over_limit <= `ASR_ZERO_BIT;
      out1_over_limit <= `ASR_ZERO_BIT;
      neg_supply_fault <= `ASR_ZERO_BIT;
    end else begin
      if (OUT_CODES_UPDATE) begin
        out4_over_limit <= OUT4_CODE > PAIR_B_UPPER_LIMIT; // [RULE1] [RULE17]
        out3_over_limit <= OUT3_CODE > PAIR_B_UPPER_LIMIT; // [RULE1]
        out2_over_limit <= OUT2_CODE > PAIR_A_UPPER_LIMIT; // [RULE2]
        out1_over_limit <= OUT1_CODE > PAIR_A_UPPER_LIMIT; // [RULE2]
      end
      if (NEG_SUPPLY_UPDATE) begin
        neg_supply_fault <= NEG_SUPPLY_FAULT; // [RULE4]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Temperature alarms
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      remote_two_over_temp <= `ASR_ZERO_BIT;
      remote_two_under_temp <= `ASR_ZERO_BIT;
      remote_one_over_temp <= `ASR_ZERO_BIT;
      remote_one_under_temp <= `ASR_ZERO_BIT;
      local_over_temp <= `ASR_ZERO_BIT;
      local_under_temp <= `ASR_ZERO_BIT;
    end else begin
      if (!REMOTE_TWO_ENABLE) begin
        remote_two_over_temp <= `ASR_ZERO_BIT; // [RULE6]
        remote_two_under_temp <= `ASR_ZERO_BIT; // [RULE6]
      end else if (REMOTE_TWO_UPDATE) begin
        remote_two_over_temp <= REMOTE_TWO_TEMP > REMOTE_TWO_HIGH; // [RULE5] [RULE17]
        remote_two_under_temp <= REMOTE_TWO_TEMP < REMOTE_TWO_LOW; // [RULE5]
      end
      if (!REMOTE_ONE_ENABLE) begin
        remote_one_over_temp <= `ASR_ZERO_BIT; // [RULE6]
        remote_one_under_temp <= `ASR_ZERO_BIT; // [RULE6]
      end else if (REMOTE_ONE_UPDATE) begin
        remote_one_over_temp <= REMOTE_ONE_TEMP > REMOTE_ONE_HIGH; // [RULE5]
        remote_one_under_temp <= REMOTE_ONE_TEMP < REMOTE_ONE_LOW; // [RULE5]
      end
      if (!LOCAL_ENABLE) begin
        local_over_temp <= `ASR_ZERO_BIT; // [RULE8]
        local_under_temp <= `ASR_ZERO_BIT; // [RULE8]
      end else if (LOCAL_UPDATE) begin
        local_over_temp <= LOCAL_TEMP > LOCAL_HIGH; // [RULE7]
        local_under_temp <= LOCAL_TEMP < LOCAL_LOW; // [RULE7]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel alarms, one per channel
  genvar gi;
  generate
    for (gi = 0; gi < CH; gi = gi + 1) begin : g_chan
      wire [DW-1:0] src = COMPARE_SOURCE_SELECT ? SENSE_VALUES[gi*DW +: DW] :
        INTERNAL_VALUES[gi*DW +: DW]; // [RULE16] [RULE9]
      always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          chan_range_fault[gi] <= `ASR_ZERO_BIT;
        end else if (CHAN_UPDATE[gi]) begin
          chan_range_fault[gi] <= out_of_range(src, CHAN_HIGH[gi*DW +: DW],
            CHAN_LOW[gi*DW +: DW]); // [RULE9] [RULE17]
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Ready flags and converter readiness
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ready_flags <= {6{`ASR_ZERO_BIT}};
      adc_ready <= `ASR_ZERO_BIT;
    end else begin
      ready_flags <= READY_FLAGS; // [RULE12]
      adc_ready <= ADC_IDLE && !CONFIG_BUSY; // [RULE14]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Word assembly
  wire [15:0] alarm_word;
  assign alarm_word[`ASR_A_OUT4] = out4_over_limit; // [RULE1]
  assign alarm_word[`ASR_A_OUT3] = out3_over_limit;
  assign alarm_word[`ASR_A_OUT2] = out2_over_limit; // [RULE2]
  assign alarm_word[`ASR_A_OUT1] = out1_over_limit;
  assign alarm_word[`ASR_A_RSVD] = `ASR_ZERO_BIT; // [RULE3]
  assign alarm_word[`ASR_A_NEG] = neg_supply_fault; // [RULE4]
  assign alarm_word[`ASR_A_R2_HI] = remote_two_over_temp; // [RULE5]
  assign alarm_word[`ASR_A_R2_LO] = remote_two_under_temp;
  assign alarm_word[`ASR_A_R1_HI] = remote_one_over_temp;
  assign alarm_word[`ASR_A_R1_LO] = remote_one_under_temp;
  assign alarm_word[`ASR_A_LT_HI] = local_over_temp; // [RULE7]
  assign alarm_word[`ASR_A_LT_LO] = local_under_temp;
  assign alarm_word[`ASR_A_CH_MSB:`ASR_A_CH_LSB] = chan_range_fault; // [RULE9]

  wire global_fault_summary = |(alarm_word & {OTHER_ALARM_ENABLE, ALARM_ENABLE});
  wire any_result_ready = |ready_flags;

  wire [15:0] general_word;
  assign general_word[`ASR_G_ANY] = any_result_ready; // [RULE12]
  assign general_word[`ASR_G_READY] = adc_ready; // [RULE14]
  assign general_word[`ASR_G_DAV_MSB:`ASR_G_DAV_LSB] = ready_flags; // [RULE12]
  assign general_word[`ASR_G_RSVD_MSB:`ASR_G_RSVD_LSB] = `ASR_ZERO_NIBBLE; // [RULE13]
  assign general_word[`ASR_G_SLEEP2] = sleep_pin_two_level; // [RULE13]
  assign general_word[`ASR_G_SLEEP1] = sleep_pin_one_level;
  assign general_word[`ASR_G_AMP] = amp_enable_pin_level; // [RULE15]
  assign general_word[`ASR_G_GLOBAL] = global_fault_summary; // [RULE13]

  assign ALARM_FLAGS = alarm_word;
  assign GENERAL_FLAGS = general_word;

  ////////////////////////////////////////////////////////////////////////
  // Read port, no side effects
  reg [15:0] next_rd_data;
  always @* begin
    if (RD_ADDR == `ASR_ADDR_ALARM) begin
      next_rd_data = alarm_word; // [RULE10] [RULE17]
    end else if (RD_ADDR == `ASR_ADDR_GENERAL) begin
      next_rd_data = general_word; // [RULE11]
    end else begin
      next_rd_data = `ASR_ZERO_WORD;
    end
  end

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RD_DATA <= `ASR_RESET_WORD; // [RULE10] [RULE11]
    end else begin
      RD_DATA <= next_rd_data;
    end
  end
endmodule // asr_status_bank
`default_nettype wire

// ### dv/asr_host.sv
// Purpose: Host side reader of the status bank
// Assumes: Index is taken at a rising edge
// Notes: Only reads exist
`timescale 1ns/1ps
`default_nettype none
module asr_host (
  input wire logic CLK,
  input wire logic [15:0] RD_DATA,
  output logic [7:0] RD_ADDR
);
  initial RD_ADDR = 8'h00;
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge CLK) RD_ADDR = a;
    @(negedge CLK) d = RD_DATA;
  endtask
endmodule // asr_host
`default_nettype wire

// ### dv/asr_status_bank_chk.sv
// Purpose: Port checks of the status bank
// Assumes: Registered reads, one-cycle updates
// Notes: Bound to the bank
`timescale 1ns/1ps
`default_nettype none
module asr_chk #(
  parameter DW = 12
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [7:0] RD_ADDR,
  input wire logic [15:0] RD_DATA,
  input wire logic [15:0] ALARM_FLAGS,
  input wire logic [15:0] GENERAL_FLAGS,
  input wire logic [DW-1:0] OUT1_CODE,
  input wire logic [DW-1:0] PAIR_A_UPPER_LIMIT,
  input wire logic OUT_CODES_UPDATE,
  input wire logic NEG_SUPPLY_FAULT,
  input wire logic NEG_SUPPLY_UPDATE,
  input wire logic [DW-1:0] LOCAL_TEMP,
  input wire logic [DW-1:0] LOCAL_HIGH,
  input wire logic LOCAL_ENABLE,
  input wire logic LOCAL_UPDATE,
  input wire logic REMOTE_ONE_ENABLE,
  input wire logic ADC_IDLE,
  input wire logic CONFIG_BUSY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  rd_alarm_a: assert property (RD_ADDR == 8'h1E |=> RD_DATA == $past(ALARM_FLAGS))
    else $error("alarm read wrong");
  rd_general_a: assert property (RD_ADDR == 8'h1F |=> RD_DATA == $past(GENERAL_FLAGS))
    else $error("general read wrong");
  rsvd_zero_a: assert property (!ALARM_FLAGS[11] && GENERAL_FLAGS[7:4] == 4'h0)
    else $error("reserved bit set");
  out_over_a: assert property (OUT_CODES_UPDATE |=>
    ALARM_FLAGS[12] == ($past(OUT1_CODE) > $past(PAIR_A_UPPER_LIMIT)))
    else $error("output alarm wrong");
  local_high_a: assert property (LOCAL_UPDATE && LOCAL_ENABLE |=>
    ALARM_FLAGS[5] == ($past(LOCAL_TEMP) > $past(LOCAL_HIGH)))
    else $error("local alarm wrong");
  local_off_a: assert property (!LOCAL_ENABLE |=> ALARM_FLAGS[5:4] == 2'h0)
    else $error("local alarm while off");
  remote_off_a: assert property (!REMOTE_ONE_ENABLE |=> ALARM_FLAGS[7:6] == 2'h0)
    else $error("remote alarm while off");
  neg_fault_a: assert property (NEG_SUPPLY_UPDATE |=> ALARM_FLAGS[10] == $past(NEG_SUPPLY_FAULT))
    else $error("supply alarm wrong");
  ready_cause_a: assert property (GENERAL_FLAGS[14] |-> $past(ADC_IDLE) && !$past(CONFIG_BUSY))
    else $error("ready while busy");
  out_hold_a: assert property (!OUT_CODES_UPDATE |=> $stable(ALARM_FLAGS[15:12]))
    else $error("output alarm moved");
endmodule // asr_chk
bind asr_status_bank asr_chk #(.DW(DW)) chk (.CLK(CLK), .RESET_N(RESET_N), .RD_ADDR(RD_ADDR),
  .RD_DATA(RD_DATA), .ALARM_FLAGS(ALARM_FLAGS), .GENERAL_FLAGS(GENERAL_FLAGS),
  .OUT1_CODE(OUT1_CODE), .PAIR_A_UPPER_LIMIT(PAIR_A_UPPER_LIMIT),
  .OUT_CODES_UPDATE(OUT_CODES_UPDATE), .NEG_SUPPLY_FAULT(NEG_SUPPLY_FAULT),
  .NEG_SUPPLY_UPDATE(NEG_SUPPLY_UPDATE), .LOCAL_TEMP(LOCAL_TEMP), .LOCAL_HIGH(LOCAL_HIGH),
  .LOCAL_ENABLE(LOCAL_ENABLE), .LOCAL_UPDATE(LOCAL_UPDATE),
  .REMOTE_ONE_ENABLE(REMOTE_ONE_ENABLE), .ADC_IDLE(ADC_IDLE), .CONFIG_BUSY(CONFIG_BUSY));
`default_nettype wire

// ### dv/tb_top.sv
// Purpose: Read tests of the status bank
// Assumes: Inputs change at falling edges
// Notes: Includes a mid-run reset
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic CLK = 1'h0, RESET_N = 1'h0;
  wire logic [7:0] RD_ADDR;
  wire logic [15:0] RD_DATA, ALARM_FLAGS, GENERAL_FLAGS;
  logic [11:0] PAIR_A_UPPER_LIMIT = 12'h800, OUT1_CODE = 12'h801, OUT2_CODE = 12'h800;
  logic [11:0] PAIR_B_UPPER_LIMIT = 12'h400, OUT3_CODE = 12'h400, OUT4_CODE = 12'h401;
  logic [11:0] LOCAL_TEMP = 12'h500, LOCAL_HIGH = 12'h4FF, LOCAL_LOW = 12'h100;
  logic [11:0] REMOTE_ONE_TEMP = 12'h050, REMOTE_ONE_HIGH = 12'h800, REMOTE_ONE_LOW = 12'h060;
  logic [11:0] REMOTE_TWO_TEMP = 12'h900, REMOTE_TWO_HIGH = 12'h800, REMOTE_TWO_LOW = 12'h060;
  logic [47:0] INTERNAL_VALUES = 48'h200200200900, SENSE_VALUES = 48'h200050200200;
  logic [47:0] CHAN_HIGH = 48'h800800800800, CHAN_LOW = 48'h100100100100;
  logic [11:0] OTHER_ALARM_ENABLE = 12'h000;
  logic [5:0] READY_FLAGS = 6'h00;
  logic [3:0] CHAN_UPDATE = 4'h0, ALARM_ENABLE = 4'h0;
  logic OUT_CODES_UPDATE = 1'h0, NEG_SUPPLY_FAULT = 1'h1, NEG_SUPPLY_UPDATE = 1'h0;
  logic LOCAL_ENABLE = 1'h1, LOCAL_UPDATE = 1'h0, REMOTE_ONE_ENABLE = 1'h1;
  logic REMOTE_ONE_UPDATE = 1'h0, REMOTE_TWO_ENABLE = 1'h1, REMOTE_TWO_UPDATE = 1'h0;
  logic COMPARE_SOURCE_SELECT = 1'h0, ADC_IDLE = 1'h0, CONFIG_BUSY = 1'h0;
  logic SLEEP_PIN_ONE = 1'h0, SLEEP_PIN_TWO = 1'h0, AMP_ENABLE_PIN = 1'h0;
  logic [15:0] d;
  int fail_count = 0, n_compared = 0;
  always #12.5 CLK = ~CLK;
  asr_status_bank dut (.CLK(CLK), .RESET_N(RESET_N), .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA),
    .OUT1_CODE(OUT1_CODE), .OUT2_CODE(OUT2_CODE), .OUT3_CODE(OUT3_CODE),
    .OUT4_CODE(OUT4_CODE), .PAIR_A_UPPER_LIMIT(PAIR_A_UPPER_LIMIT),
    .PAIR_B_UPPER_LIMIT(PAIR_B_UPPER_LIMIT), .OUT_CODES_UPDATE(OUT_CODES_UPDATE),
    .NEG_SUPPLY_FAULT(NEG_SUPPLY_FAULT), .NEG_SUPPLY_UPDATE(NEG_SUPPLY_UPDATE),
    .LOCAL_TEMP(LOCAL_TEMP), .LOCAL_HIGH(LOCAL_HIGH), .LOCAL_LOW(LOCAL_LOW),
    .LOCAL_ENABLE(LOCAL_ENABLE), .LOCAL_UPDATE(LOCAL_UPDATE),
    .REMOTE_ONE_TEMP(REMOTE_ONE_TEMP), .REMOTE_ONE_HIGH(REMOTE_ONE_HIGH),
    .REMOTE_ONE_LOW(REMOTE_ONE_LOW), .REMOTE_ONE_ENABLE(REMOTE_ONE_ENABLE),
    .REMOTE_ONE_UPDATE(REMOTE_ONE_UPDATE), .REMOTE_TWO_TEMP(REMOTE_TWO_TEMP),
    .REMOTE_TWO_HIGH(REMOTE_TWO_HIGH), .REMOTE_TWO_LOW(REMOTE_TWO_LOW),
    .REMOTE_TWO_ENABLE(REMOTE_TWO_ENABLE), .REMOTE_TWO_UPDATE(REMOTE_TWO_UPDATE),
    .INTERNAL_VALUES(INTERNAL_VALUES), .SENSE_VALUES(SENSE_VALUES),
    .CHAN_HIGH(CHAN_HIGH), .CHAN_LOW(CHAN_LOW), .CHAN_UPDATE(CHAN_UPDATE),
    .COMPARE_SOURCE_SELECT(COMPARE_SOURCE_SELECT), .READY_FLAGS(READY_FLAGS),
    .ADC_IDLE(ADC_IDLE), .CONFIG_BUSY(CONFIG_BUSY), .ALARM_ENABLE(ALARM_ENABLE),
    .OTHER_ALARM_ENABLE(OTHER_ALARM_ENABLE), .SLEEP_PIN_ONE(SLEEP_PIN_ONE),
    .SLEEP_PIN_TWO(SLEEP_PIN_TWO), .AMP_ENABLE_PIN(AMP_ENABLE_PIN),
    .ALARM_FLAGS(ALARM_FLAGS), .GENERAL_FLAGS(GENERAL_FLAGS));
  asr_host host (.CLK(CLK), .RD_DATA(RD_DATA), .RD_ADDR(RD_ADDR));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic conclude;
    if (fail_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic pulse;
    OUT_CODES_UPDATE = 1'h1;
    NEG_SUPPLY_UPDATE = 1'h1;
    LOCAL_UPDATE = 1'h1;
    REMOTE_ONE_UPDATE = 1'h1;
    REMOTE_TWO_UPDATE = 1'h1;
    CHAN_UPDATE = 4'hF;
    @(negedge CLK);
    OUT_CODES_UPDATE = 1'h0;
    NEG_SUPPLY_UPDATE = 1'h0;
    LOCAL_UPDATE = 1'h0;
    REMOTE_ONE_UPDATE = 1'h0;
    REMOTE_TWO_UPDATE = 1'h0;
    CHAN_UPDATE = 4'h0;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge CLK);
    RESET_N = 1'h1;
    host.rd(8'h1E, d); chk(d, 16'h0000);
    host.rd(8'h1F, d); chk(d, 16'h0000);
    host.rd(8'h20, d); chk(d, 16'h0000);
    pulse();
    host.rd(8'h1E, d); chk(d, 16'h9661);
    chk(ALARM_FLAGS, 16'h9661);
    COMPARE_SOURCE_SELECT = 1'h1;
    OUT1_CODE = 12'h800;
    OUT2_CODE = 12'h801;
    NEG_SUPPLY_FAULT = 1'h0;
    REMOTE_ONE_TEMP = 12'h900;
    REMOTE_TWO_TEMP = 12'h050;
    LOCAL_TEMP = 12'h0FF;
    pulse();
    host.rd(8'h1E, d); chk(d, 16'hA194);
    host.rd(8'h1E, d); chk(d, 16'hA194);
    LOCAL_ENABLE = 1'h0;
    REMOTE_ONE_ENABLE = 1'h0;
    REMOTE_TWO_ENABLE = 1'h0;
    pulse();
    host.rd(8'h1E, d); chk(d, 16'hA004);
    READY_FLAGS = 6'h2A;
    ADC_IDLE = 1'h1;
    SLEEP_PIN_TWO = 1'h1;
    AMP_ENABLE_PIN = 1'h1;
    repeat (3) @(negedge CLK);
    host.rd(8'h1F, d); chk(d, 16'hEA0A);
    chk(GENERAL_FLAGS, 16'hEA0A);
    ALARM_ENABLE = 4'h4;
    CONFIG_BUSY = 1'h1;
    AMP_ENABLE_PIN = 1'h0;
    SLEEP_PIN_ONE = 1'h1;
    repeat (3) @(negedge CLK);
    host.rd(8'h1F, d); chk(d, 16'hAA0D);
    ALARM_ENABLE = 4'h0;
    OTHER_ALARM_ENABLE = 12'h200;
    host.rd(8'h1F, d); chk(d, 16'hAA0D);
    RESET_N = 1'h0;
    repeat (2) @(negedge CLK);
    RESET_N = 1'h1;
    host.rd(8'h1E, d); chk(d, 16'h0000);
    conclude();
  end
  initial begin
    #200000;
    fail_count++;
    conclude();
  end
endmodule // tb_top
`default_nettype wire
